// ### pkg/cec_pkg.sv
// constants and types of the comparator event control block
// assumes a 32-bit axi4-lite master and an analog core outside
// Contract
// - an enabled comparator and its event logic keep working through wait mode
// - in wait, a qualifying event with irq enable set raises a waking interrupt
// - in retaining stop an enabled comparator keeps comparing and detecting events
// - in retaining stop the pin output still follows the result when enabled
// - in retaining stop an event sets the flag and wakes if irq enable is set
// - leaving stop through reset returns every control and status bit to reset
// - partial powerdown stop unpowers the comparator; wake-up finds logic reset, except the write-once power bits, which keep their values
// - in active background debug the comparator works as in run mode
// - reference select picks bandgap or positive pin for the non-inverting input
// - result is high when non-inverting input exceeds inverting, else low
// - edge select sets the flag on rising, falling or either output edge
// - a read-only bit returns the present result, independent of the flag
// - pin output enable drives result onto the pin, else pin is undriven
// - write-once powerdown variant bit: zero retaining stop, one partial powerdown
package cec_pkg;
    // byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_POWER  = 8'h0c;
    // control fields
    localparam int CTRL_EN      = 0;
    localparam int CTRL_REF     = 1;
    localparam int CTRL_PIN_OE  = 2;
    localparam int CTRL_EDGE_LO = 3;
    localparam int CTRL_IRQ_EN  = 5;
    // status and mask fields
    localparam int STAT_FLAG    = 0;
    localparam int STAT_LIVE    = 1;
    // power fields
    localparam int PWR_VARIANT  = 0;
    localparam int PWR_LOCKED   = 1;
    // reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic       MASK_RST = 1'b1;
    localparam logic       VAR_RST  = 1'b0;
    // edge select codes; 2'h2 also counts as falling
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_ANY  = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // power states of the block
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_KEEP,
        PWR_OFF
    } cec_pwr_t;
endpackage : cec_pkg

// ### core/cec_sync.sv
// two-flop synchroniser for the raw comparator result
// assumes input is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module cec_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // data
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // first stage feeds only the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : cec_sync
`default_nettype wire

// ### core/cec_edge.sv
// edge qualifier: one-cycle event pulse on the selected output edge
// assumes level is already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
module cec_edge (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // control
    input  wire logic       active,
    input  wire logic [1:0] edge_sel,
    // data
    input  wire logic       level,
    output var  logic       event_pulse
);
    logic prev_q;
    logic prev_d;

    // tracking while idle keeps a stale level from faking an edge
    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    always_comb begin
        event_pulse = 1'b0;
        if (active) begin
            unique case (edge_sel)
                cec_pkg::EDGE_RISE: event_pulse = level & ~prev_q;
                cec_pkg::EDGE_ANY:  event_pulse = level ^ prev_q;
                default:            event_pulse = ~level & prev_q;
            endcase
        end
    end
endmodule : cec_edge
`default_nettype wire

// ### core/cec_top.sv
// comparator event control: registers, event flag, wake and pin logic
// assumes analog core gives an async result and takes ref select/enable
`timescale 1ns/1ps
`default_nettype none
module cec_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output var  logic [1:0]        s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    // axi4-lite read data
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    // processor mode
    input  wire logic              wait_mode,
    input  wire logic              stop_mode,
    input  wire logic              bdm_active,
    // analog core
    input  wire logic              cmp_raw_result,
    output var  logic              cmp_analog_enable,
    output var  logic              cmp_ref_select,
    // pin and interrupt
    output var  logic              cmp_output_pin,
    output var  logic              cmp_output_pin_oe,
    output var  logic              cmp_irq,
    output var  logic              cmp_wake
);
    initial begin
        // offsets are decoded on 8 bits and the top bits flag unmapped space
        if (ADDR_W < 5 || ADDR_W > 8) begin
            $error("cec_top: ADDR_W must be 5 to 8");
        end
    end

    // control state
    logic                 en_q, en_d;
    logic                 ref_q, ref_d;
    logic                 pin_oe_q, pin_oe_d;
    logic [1:0]           edge_q, edge_d;
    logic                 irq_en_q, irq_en_d;
    logic                 flag_q, flag_d;
    logic                 mask_q, mask_d;
    logic                 variant_q, variant_d;
    logic                 locked_q, locked_d;
    cec_pkg::cec_pwr_t    pwr_q, pwr_d;
    // outputs
    logic                 analog_en_q, analog_en_d;
    logic                 ref_out_q, ref_out_d;
    logic                 pin_q, pin_d;
    logic                 pin_en_q, pin_en_d;
    logic                 irq_q, irq_d;
    logic                 wake_q, wake_d;
    // bus state
    logic                 aw_have_q, aw_have_d;
    logic [ADDR_W-1:0]    aw_addr_q, aw_addr_d;
    logic                 w_have_q, w_have_d;
    logic [7:0]           w_byte_q, w_byte_d;
    logic                 w_lane_q, w_lane_d;
    logic                 awready_q, awready_d;
    logic                 wready_q, wready_d;
    logic                 bvalid_q, bvalid_d;
    logic [1:0]           bresp_q, bresp_d;
    logic                 arready_q, arready_d;
    logic                 rvalid_q, rvalid_d;
    logic [31:0]          rdata_q, rdata_d;
    logic [1:0]           rresp_q, rresp_d;

    logic live;
    logic evt;
    logic powered;
    logic wr_fire;
    logic rd_fire;
    logic wake_reset;
    logic [7:0] wofs;
    logic [7:0] rofs;

    cec_sync u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (cmp_raw_result),
        .sync_out (live)
    );

    // analog core already gives high for plus above minus
    cec_edge u_edge (
        .clock       (clock),
        .nrst        (nrst),
        .active      (powered),
        .edge_sel    (edge_q),
        .level       (live),
        .event_pulse (evt)
    );

    // wait, retaining stop and debug all leave the comparator running
    assign powered = en_q && (pwr_q != cec_pkg::PWR_OFF);
    assign wake_reset = (pwr_q == cec_pkg::PWR_OFF) && !stop_mode;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid && arready_q;
    assign wofs = 8'(aw_addr_q) & 8'hfc;
    assign rofs = 8'(s_axi_araddr) & 8'hfc;

    // power state
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            cec_pkg::PWR_RUN: begin
                if (stop_mode && !bdm_active) begin
                    pwr_d = variant_q ? cec_pkg::PWR_OFF : cec_pkg::PWR_KEEP;
                end
            end
            cec_pkg::PWR_KEEP: begin
                if (!stop_mode) begin
                    pwr_d = cec_pkg::PWR_RUN;
                end
            end
            cec_pkg::PWR_OFF: begin
                if (!stop_mode) begin
                    pwr_d = cec_pkg::PWR_RUN;
                end
            end
        endcase
    end

    // registers seen by software
    always_comb begin
        en_d      = en_q;
        ref_d     = ref_q;
        pin_oe_d  = pin_oe_q;
        edge_d    = edge_q;
        irq_en_d  = irq_en_q;
        mask_d    = mask_q;
        variant_d = variant_q;
        locked_d  = locked_q;
        flag_d    = flag_q;
        if (wr_fire && w_lane_q) begin
            unique case (wofs)
                cec_pkg::OFS_CTRL: begin
                    en_d     = w_byte_q[cec_pkg::CTRL_EN];
                    ref_d    = w_byte_q[cec_pkg::CTRL_REF];
                    pin_oe_d = w_byte_q[cec_pkg::CTRL_PIN_OE];
                    edge_d   = w_byte_q[cec_pkg::CTRL_EDGE_LO +: 2];
                    irq_en_d = w_byte_q[cec_pkg::CTRL_IRQ_EN];
                end
                cec_pkg::OFS_STATUS: begin
                    if (w_byte_q[cec_pkg::STAT_FLAG]) begin
                        flag_d = 1'b0;
                    end
                end
                cec_pkg::OFS_MASK: begin
                    mask_d = w_byte_q[cec_pkg::STAT_FLAG];
                end
                cec_pkg::OFS_POWER: begin
                    if (!locked_q) begin
                        variant_d = w_byte_q[cec_pkg::PWR_VARIANT];
                        locked_d  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        if (evt) begin
            flag_d = 1'b1;
        end
        if (wake_reset) begin
            en_d      = cec_pkg::CTRL_RST[cec_pkg::CTRL_EN];
            ref_d     = cec_pkg::CTRL_RST[cec_pkg::CTRL_REF];
            pin_oe_d  = cec_pkg::CTRL_RST[cec_pkg::CTRL_PIN_OE];
            edge_d    = cec_pkg::CTRL_RST[cec_pkg::CTRL_EDGE_LO +: 2];
            irq_en_d  = cec_pkg::CTRL_RST[cec_pkg::CTRL_IRQ_EN];
            flag_d    = 1'b0;
            mask_d    = cec_pkg::MASK_RST;
        end
    end

    // outputs, all registered
    always_comb begin
        analog_en_d = powered;
        ref_out_d   = ref_q;
        pin_en_d    = pin_oe_q && powered;
        pin_d       = pin_oe_q && powered && live;
        irq_d       = flag_d && irq_en_d && mask_d;
        wake_d      = flag_d && irq_en_d && mask_d
                      && (wait_mode || pwr_q == cec_pkg::PWR_KEEP);
    end

    // write channel: address and data taken in either order
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wofs > cec_pkg::OFS_POWER) ? cec_pkg::RESP_SLVERR
                                                    : cec_pkg::RESP_OKAY;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // one write in flight until its response is taken
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
    end

    // read channel
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rdata_d  = 32'h0000_0000;
            rresp_d  = cec_pkg::RESP_OKAY;
            unique case (rofs)
                cec_pkg::OFS_CTRL: begin
                    rdata_d[cec_pkg::CTRL_EN]           = en_q;
                    rdata_d[cec_pkg::CTRL_REF]          = ref_q;
                    rdata_d[cec_pkg::CTRL_PIN_OE]       = pin_oe_q;
                    rdata_d[cec_pkg::CTRL_EDGE_LO +: 2] = edge_q;
                    rdata_d[cec_pkg::CTRL_IRQ_EN]       = irq_en_q;
                end
                cec_pkg::OFS_STATUS: begin
                    rdata_d[cec_pkg::STAT_FLAG] = flag_q;
                    rdata_d[cec_pkg::STAT_LIVE] = live;
                end
                cec_pkg::OFS_MASK: begin
                    rdata_d[cec_pkg::STAT_FLAG] = mask_q;
                end
                cec_pkg::OFS_POWER: begin
                    rdata_d[cec_pkg::PWR_VARIANT] = variant_q;
                    rdata_d[cec_pkg::PWR_LOCKED]  = locked_q;
                end
                default: begin
                    rresp_d = cec_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    // system reset loads every bit with its reset value (mask set, the rest clear), also when it ends a stop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_q        <= cec_pkg::CTRL_RST[cec_pkg::CTRL_EN];
            ref_q       <= cec_pkg::CTRL_RST[cec_pkg::CTRL_REF];
            pin_oe_q    <= cec_pkg::CTRL_RST[cec_pkg::CTRL_PIN_OE];
            edge_q      <= cec_pkg::CTRL_RST[cec_pkg::CTRL_EDGE_LO +: 2];
            irq_en_q    <= cec_pkg::CTRL_RST[cec_pkg::CTRL_IRQ_EN];
            flag_q      <= 1'b0;
            mask_q      <= cec_pkg::MASK_RST;
            variant_q   <= cec_pkg::VAR_RST;
            locked_q    <= 1'b0;
            pwr_q       <= cec_pkg::PWR_RUN;
            analog_en_q <= 1'b0;
            ref_out_q   <= 1'b0;
            pin_q       <= 1'b0;
            pin_en_q    <= 1'b0;
            irq_q       <= 1'b0;
            wake_q      <= 1'b0;
        end else begin
            en_q        <= en_d;
            ref_q       <= ref_d;
            pin_oe_q    <= pin_oe_d;
            edge_q      <= edge_d;
            irq_en_q    <= irq_en_d;
            flag_q      <= flag_d;
            mask_q      <= mask_d;
            variant_q   <= variant_d;
            locked_q    <= locked_d;
            pwr_q       <= pwr_d;
            analog_en_q <= analog_en_d;
            ref_out_q   <= ref_out_d;
            pin_q       <= pin_d;
            pin_en_q    <= pin_en_d;
            irq_q       <= irq_d;
            wake_q      <= wake_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= cec_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= cec_pkg::RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;
    assign cmp_analog_enable = analog_en_q;
    assign cmp_ref_select    = ref_out_q;
    assign cmp_output_pin    = pin_q;
    assign cmp_output_pin_oe = pin_en_q;
    assign cmp_irq           = irq_q;
    assign cmp_wake          = wake_q;
endmodule : cec_top
`default_nettype wire

// ### sim/cec_analog_model.sv
// behavioural analog comparator core facing the control block
// assumes voltages are small unsigned codes set by the bench
`timescale 1ns/1ps
`default_nettype none
module cec_analog_model (
    // core controls
    input  wire logic       enable,
    input  wire logic       ref_sel,
    // input levels
    input  wire logic [7:0] v_pos,
    input  wire logic [7:0] v_neg,
    input  wire logic [7:0] v_gap,
    // result
    output var  logic       raw
);
    logic [7:0] v_ninv;
    always_comb begin
        v_ninv = ref_sel ? v_gap : v_pos;
        // unpowered core gives a quiet low output
        raw = enable && (v_ninv > v_neg);
    end
endmodule : cec_analog_model
`default_nettype wire

// ### sim/cec_top_sva.sv
// port-level checker of the comparator event control block
// assumes single clock domain and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module cec_top_sva #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              nrst,
    // bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    // comparator side
    input wire logic              cmp_raw_result,
    input wire logic              cmp_output_pin,
    input wire logic              cmp_output_pin_oe,
    input wire logic              cmp_irq,
    input wire logic              cmp_wake
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answering");
    // three flops from raw input to pin: two sync, one output
    pin_follow_a: assert property (
        cmp_output_pin_oe && $past(cmp_output_pin_oe, 3)
        |-> cmp_output_pin == $past(cmp_raw_result, 3)) else $error("pin not following");
    wake_irq_a: assert property (!cmp_irq && !$past(cmp_irq) |-> !cmp_wake)
        else $error("wake without interrupt");
    live_read_a: assert property (
        $rose(s_axi_rvalid) && $past(s_axi_araddr[3:0]) == 4'h4
        |-> s_axi_rdata[1] == $past(cmp_raw_result, 3)) else $error("live bit wrong");
    unmapped_err_a: assert property ($rose(s_axi_rvalid)
        && $past(s_axi_araddr[ADDR_W-1:4]) != '0
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule : cec_top_sva
bind cec_top cec_top_sva #(.ADDR_W(ADDR_W)) u_sva (.clock, .nrst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .cmp_raw_result, .cmp_output_pin, .cmp_output_pin_oe, .cmp_irq, .cmp_wake);
`default_nettype wire

// ### sim/cec_top_tb_top.sv
// self-checking bench of the comparator event control block
// assumes the analog model stands in for the core; mode inputs driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("wrong value at %0t: %h vs %h", $time, g, e); \
        end \
    end
module cec_top_tb_top;
    logic        clock, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, v_pos;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        wait_mode, stop_mode, bdm_active, cmp_raw_result;
    logic        cmp_analog_enable, cmp_ref_select, cmp_output_pin;
    logic        cmp_output_pin_oe, cmp_irq, cmp_wake;
    int          mismatches, n_tests, cyc;

    cec_top #(.ADDR_W(8)) uut (.clock, .nrst, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .wait_mode, .stop_mode, .bdm_active, .cmp_raw_result,
        .cmp_analog_enable, .cmp_ref_select, .cmp_output_pin,
        .cmp_output_pin_oe, .cmp_irq, .cmp_wake);
    cec_analog_model u_ana (.enable(cmp_analog_enable), .ref_sel(cmp_ref_select),
        .v_pos(v_pos), .v_neg(8'h80), .v_gap(8'hc0), .raw(cmp_raw_result));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask : tk

    // all bus tasks enter and leave just after a rising edge
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        `CHK(s_axi_bresp, (a > 8'h0f) ? cec_pkg::RESP_SLVERR : cec_pkg::RESP_OKAY)
    endtask : w

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, (a > 8'h0f) ? cec_pkg::RESP_SLVERR : cec_pkg::RESP_OKAY)
    endtask : rc

    // pin result settles three edges after a level change, irq on the same edge
    task automatic vp(input logic [7:0] v);
        v_pos <= v;
        tk(6);
    endtask : vp

    task automatic t_regs;
        rc(8'h00, 32'h0);
        // low byte lane off: the write must be answered but ignored
        s_axi_wstrb <= 4'he;
        w(8'h08, 32'h0);
        s_axi_wstrb <= 4'hf;
        rc(8'h08, 32'h1);
        rc(8'h0c, 32'h0);
        rc(8'h10, 32'h0);
        w(8'h20, 32'hff);
    endtask : t_regs

    task automatic t_edge;
        logic [1:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i[1:0];
            vp(8'h00);
            w(8'h00, 32'h21 | {27'h0, e, 3'h0});
            w(8'h04, 32'h1);
            vp(8'hff);
            `CHK(cmp_irq, e[0])
            w(8'h08, 32'h0);
            tk(2);
            `CHK(cmp_irq, 1'b0)
            w(8'h08, 32'h1);
            w(8'h04, 32'h1);
            tk(2);
            `CHK(cmp_irq, 1'b0)
            vp(8'h00);
            `CHK(cmp_irq, e != 2'h1)
        end
        w(8'h04, 32'h1);
    endtask : t_edge

    task automatic t_wait;
        w(8'h00, 32'h29);
        wait_mode <= 1'b1;
        vp(8'hff);
        `CHK(cmp_wake, 1'b1)
        w(8'h04, 32'h1);
        vp(8'h00);
        w(8'h00, 32'h00);
        vp(8'hff);
        `CHK(cmp_analog_enable, 1'b0)
        `CHK(cmp_wake, 1'b0)
        vp(8'h00);
        wait_mode <= 1'b0;
    endtask : t_wait

    task automatic t_ref;
        w(8'h00, 32'h03);
        tk(4);
        `CHK(cmp_ref_select, 1'b1)
        rc(8'h04, 32'h2);
        w(8'h00, 32'h01);
        tk(4);
        rc(8'h04, 32'h1);
        w(8'h04, 32'h1);
    endtask : t_ref

    task automatic t_partial_powerdown_stop;
        w(8'h0c, 32'h1);
        w(8'h0c, 32'h0);
        rc(8'h0c, 32'h3);
        w(8'h00, 32'h2d);
        stop_mode <= 1'b1;
        tk(3);
        `CHK(cmp_analog_enable, 1'b0)
        `CHK(cmp_output_pin_oe, 1'b0)
        vp(8'hff);
        stop_mode <= 1'b0;
        tk(3);
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0);
        vp(8'h00);
    endtask : t_partial_powerdown_stop

    task automatic t_bdm;
        w(8'h00, 32'h29);
        bdm_active <= 1'b1;
        stop_mode  <= 1'b1;
        vp(8'hff);
        `CHK(cmp_analog_enable, 1'b1)
        `CHK(cmp_irq, 1'b1)
        stop_mode  <= 1'b0;
        bdm_active <= 1'b0;
    endtask : t_bdm

    task automatic t_rst;
        tk(1);
        stop_mode <= 1'b1;
        tk(2);
        nrst <= 1'b0;
        tk(2);
        stop_mode <= 1'b0;
        nrst      <= 1'b1;
        tk(2);
        `CHK(cmp_irq, 1'b0)
        rc(8'h00, 32'h0);
        rc(8'h08, 32'h1);
        rc(8'h0c, 32'h0);
    endtask : t_rst

    task automatic t_retaining_stop;
        vp(8'h00);
        w(8'h00, 32'h2d);
        stop_mode <= 1'b1;
        vp(8'hff);
        `CHK(cmp_output_pin_oe, 1'b1)
        `CHK(cmp_output_pin, 1'b1)
        `CHK(cmp_wake, 1'b1)
        vp(8'h00);
        `CHK(cmp_output_pin, 1'b0)
        stop_mode <= 1'b0;
        w(8'h00, 32'h29);
        tk(3);
        `CHK(cmp_output_pin_oe, 1'b0)
    endtask : t_retaining_stop

    initial begin
        forever begin
            @(posedge clock);
            cyc++;
            if (cyc > 20000) begin
                mismatches++;
                finish_test();
            end
        end
    end

    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, wait_mode, stop_mode, bdm_active} = '0;
        {s_axi_awaddr, s_axi_araddr, v_pos, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        tk(10);
        nrst <= 1'b1;
        tk(2);
        t_regs();
        t_edge();
        t_wait();
        t_ref();
        t_partial_powerdown_stop();
        t_bdm();
        t_rst();
        t_retaining_stop();
        finish_test();
    end
endmodule : cec_top_tb_top
`default_nettype wire
